// ===== logic/config_load_crc_recovery.sv
// Configuration loader with address generation, frame CRC check and brown-out recovery.
`timescale 1ns/1ps
`default_nettype none
module config_load_crc_recovery
    import cfg_load_pkg::*;
#(
    parameter int FRAME_LEN   = cfg_load_pkg::FRAME_BYTES,
    parameter int FRAMES      = cfg_load_pkg::FRAME_COUNT,
    parameter int INIT_LEN    = cfg_load_pkg::INIT_CYCLES
) (
    input  wire logic                            CLK_I,
    input  wire logic                            RESET_N_I,
    input  wire logic                            CONFIG_RESTART_N_I,
    input  wire logic                            ASCENDING_PARALLEL_SCHEME_I,
    input  wire logic                            DESCENDING_PARALLEL_SCHEME_I,
    input  wire logic                            SUPPLY_OK_I,
    output logic      [cfg_load_pkg::ADDR_W-1:0] MEM_ADDR_O,
    output logic                                 MEM_READ_O,
    input  wire logic                            MEM_VALID_I,
    input  wire logic [cfg_load_pkg::DATA_W-1:0] MEM_DATA_I,
    output logic                                 ARRAY_VALID_O,
    input  wire logic                            ARRAY_READY_I,
    output logic      [cfg_load_pkg::DATA_W-1:0] ARRAY_DATA_O,
    input  wire logic                            STATUS_ERROR_N_I,
    output logic                                 STATUS_ERROR_N_O,
    output logic                                 STATUS_ERROR_N_OE_O,
    output logic                                 CRC_ERROR_O,
    output logic                                 BROWNOUT_ERROR_O,
    output logic                                 CONFIGURING_O,
    output logic                                 USER_MODE_O
);
    import cfg_load_pkg::*;

    initial begin
        if (FRAME_LEN < 1 || FRAME_LEN > 65535 || FRAMES < 1 || FRAMES > 65535
            || INIT_LEN < 1 || INIT_LEN > 65535) begin
            $error("config_load_crc_recovery: counts must lie in 1..65535.");
        end
    end

    localparam logic [15:0] LAST_BYTE  = 16'(FRAME_LEN - 1);  // Last payload index.
    localparam logic [15:0] LAST_FRAME = 16'(FRAMES - 1);     // Last frame index.
    localparam logic [15:0] LAST_INIT  = 16'(INIT_LEN - 1);   // Last init cycle.

    load_state_t         state;          // Loader state.
    load_state_t         next_state;     // Next loader state.
    field_t              field;          // Field of the frame being taken.
    field_t              next_field;     // Next field.
    logic [ADDR_W-1:0]   addr;           // Current memory address.
    logic [ADDR_W-1:0]   next_addr;      // Next memory address.
    logic                descend;        // Scheme latched at start.
    logic                next_descend;   // Next scheme value.
    logic [15:0]         byte_cnt;       // Payload byte count in frame.
    logic [15:0]         next_byte_cnt;  // Next payload count.
    logic [15:0]         frame_cnt;      // Frame count.
    logic [15:0]         next_frame_cnt; // Next frame count.
    logic [15:0]         init_cnt;       // Initialization cycle count.
    logic [15:0]         next_init_cnt;  // Next init count.
    logic [15:0]         crc;            // Running frame CRC.
    logic [15:0]         next_crc;       // Next running CRC.
    logic [7:0]          crc_lo;         // Low byte of the stream check value.
    logic [7:0]          next_crc_lo;    // Next low check byte.
    logic                crc_err;        // Latched CRC error.
    logic                next_crc_err;   // Next CRC error.
    logic                bo_err;         // Latched brown-out error.
    logic                next_bo_err;    // Next brown-out error.
    logic                restart_q;      // Restart pin one cycle ago.
    logic                buf_ready;      // Buffer accepts a byte.
    logic                buf_push;       // Payload byte offered to the buffer.
    logic                take;           // A memory byte is taken this cycle.
    logic                flush;          // Drop buffered bytes.
    logic                start_req;      // A new configuration start.

    // Bytewise CRC update, most significant bit of the register first.
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            if (r[15] ^ d[i]) begin
                r = {r[14:0], 1'b0} ^ CRC_POLY;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction

    // Start on a restart rising edge, or automatically once supply is back with
    // restart tied high after a brown-out; host restart otherwise.
    assign start_req = SUPPLY_OK_I && CONFIG_RESTART_N_I
                       && (!restart_q || (bo_err && state == ST_ERROR));

    // A byte is taken only while reading and the buffer has room for payload.
    assign take     = MEM_READ_O && MEM_VALID_I && (field != FLD_DATA || buf_ready);
    assign buf_push = MEM_READ_O && MEM_VALID_I && field == FLD_DATA;
    assign flush    = (state != ST_LOAD && state != ST_CHECK && state != ST_INIT)
                      || start_req;

    // Next values of the loader.
    always_comb begin
        next_state     = state;
        next_field     = field;
        next_addr      = addr;
        next_descend   = descend;
        next_byte_cnt  = byte_cnt;
        next_frame_cnt = frame_cnt;
        next_init_cnt  = init_cnt;
        next_crc       = crc;
        next_crc_lo    = crc_lo;
        next_crc_err   = crc_err;
        next_bo_err    = bo_err;
        if (!SUPPLY_OK_I) begin
            // Failing supply stops everything and latches the error.
            next_state  = ST_ERROR;
            next_bo_err = 1'b1;
        end else if (!CONFIG_RESTART_N_I) begin
            // Restart held low keeps the loader idle.
            next_state = ST_IDLE;
        end else if (start_req) begin
            // A new start clears latched errors and sets the base address.
            next_state     = ST_LOAD;
            next_crc_err   = 1'b0;
            next_bo_err    = 1'b0;
            next_descend   = DESCENDING_PARALLEL_SCHEME_I && !ASCENDING_PARALLEL_SCHEME_I;
            next_addr      = next_descend ? ADDR_HIGH : ADDR_LOW;
            next_field     = FLD_DATA;
            next_byte_cnt  = '0;
            next_frame_cnt = '0;
            next_crc       = CRC_INIT;
        end else begin
            case (state)
                ST_LOAD: begin
                    if (take) begin
                        // Only the base sequence is driven; offsets are external.
                        next_addr = descend ? addr - 1'b1 : addr + 1'b1;
                        case (field)
                            FLD_DATA: begin
                                next_crc = crc_byte(crc, MEM_DATA_I);
                                if (byte_cnt == LAST_BYTE) begin
                                    next_field = FLD_CRC_LO;
                                end
                                next_byte_cnt = byte_cnt + 16'd1;
                            end
                            FLD_CRC_LO: begin
                                next_crc_lo = MEM_DATA_I;
                                next_field  = FLD_CRC_HI;
                            end
                            FLD_CRC_HI: begin
                                next_field = FLD_DATA;
                                next_state = ST_CHECK;
                            end
                            default: begin
                                next_field = FLD_DATA;
                            end
                        endcase
                        if (field == FLD_CRC_HI) begin
                            // Compare computed CRC with the stream value.
                            if ({MEM_DATA_I, crc_lo} != crc) begin
                                next_state   = ST_ERROR;
                                next_crc_err = 1'b1;
                            end
                        end
                    end
                end
                ST_CHECK: begin
                    // Frame passed; start the next or initialize after the last.
                    next_crc      = CRC_INIT;
                    next_byte_cnt = '0;
                    if (frame_cnt == LAST_FRAME) begin
                        next_state    = ST_INIT;
                        next_init_cnt = '0;
                    end else begin
                        next_frame_cnt = frame_cnt + 16'd1;
                        next_state     = ST_LOAD;
                    end
                end
                ST_INIT: begin
                    // Initialization ends in user mode once the buffer drained.
                    if (init_cnt == LAST_INIT && !ARRAY_VALID_O) begin
                        next_state = ST_USER;
                    end else if (init_cnt != LAST_INIT) begin
                        next_init_cnt = init_cnt + 16'd1;
                    end
                end
                ST_USER: begin
                    next_state = ST_USER;
                end
                ST_ERROR: begin
                    // Stays halted until a restart rising edge, or supply return after a brown-out with restart high, reloads the device.
                    next_state = ST_ERROR;
                end
                ST_IDLE: begin
                    next_state = ST_IDLE;
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    // Register the loader state.
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state     <= ST_IDLE;
            field     <= FLD_DATA;
            addr      <= ADDR_LOW;
            descend   <= 1'b0;
            byte_cnt  <= '0;
            frame_cnt <= '0;
            init_cnt  <= '0;
            crc       <= CRC_INIT;
            crc_lo    <= '0;
            crc_err   <= 1'b0;
            bo_err    <= 1'b0;
            restart_q <= 1'b0;
        end else begin
            state     <= next_state;
            field     <= next_field;
            addr      <= next_addr;
            descend   <= next_descend;
            byte_cnt  <= next_byte_cnt;
            frame_cnt <= next_frame_cnt;
            init_cnt  <= next_init_cnt;
            crc       <= next_crc;
            crc_lo    <= next_crc_lo;
            crc_err   <= next_crc_err;
            bo_err    <= next_bo_err;
            restart_q <= CONFIG_RESTART_N_I;
        end
    end

    // Payload bytes pass through a two-entry buffer so a stalled array loses none.
    cfg_skid_buffer #(
        .WIDTH(DATA_W),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clk_i      (CLK_I),
        .reset_n_i  (RESET_N_I),
        .flush_i    (flush),
        .in_valid_i (buf_push),
        .in_ready_o (buf_ready),
        .in_data_i  (MEM_DATA_I),
        .out_valid_o(ARRAY_VALID_O),
        .out_ready_i(ARRAY_READY_I),
        .out_data_o (ARRAY_DATA_O)
    );

    // Outputs; the open-drain status pin pulls low while an error is latched.
    assign MEM_ADDR_O          = addr;
    assign MEM_READ_O          = (state == ST_LOAD);
    assign STATUS_ERROR_N_O    = 1'b0;
    assign STATUS_ERROR_N_OE_O = crc_err || bo_err;
    assign CRC_ERROR_O         = crc_err;
    assign BROWNOUT_ERROR_O    = bo_err;
    assign CONFIGURING_O       = (state == ST_LOAD || state == ST_CHECK || state == ST_INIT);
    assign USER_MODE_O         = (state == ST_USER);
endmodule
`default_nettype wire

// ===== logic/cfg_load_pkg.sv
// Package with constants and types shared by the configuration loader.
package cfg_load_pkg;
    localparam int ADDR_W = 18;                       // Width of the memory address.
    localparam int DATA_W = 8;                        // Width of one configuration byte.
    localparam logic [17:0] ADDR_LOW = 18'h00000;     // Lowest memory address.
    localparam logic [17:0] ADDR_HIGH = 18'h3ffff;    // Highest memory address.
    localparam logic [15:0] CRC_INIT = 16'hffff;      // CRC seed at the start of a frame.
    localparam logic [15:0] CRC_POLY = 16'h1021;      // CRC generator polynomial.
    localparam int FRAME_BYTES = 16;                  // Default payload bytes per frame.
    localparam int FRAME_COUNT = 64;                  // Default frames per configuration.
    localparam int INIT_CYCLES = 16;                  // Default initialization length.
    localparam int BUF_DEPTH = 2;                     // Entries in the output buffer.
    // Loader states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOAD,
        ST_CHECK,
        ST_INIT,
        ST_USER,
        ST_ERROR
    } load_state_t;
    // Frame field being received.
    typedef enum logic [1:0] {
        FLD_DATA,
        FLD_CRC_LO,
        FLD_CRC_HI
    } field_t;
endpackage

// ===== logic/cfg_skid_buffer.sv
// Two-entry buffer holding configuration bytes on their way to the array.
`timescale 1ns/1ps
`default_nettype none
module cfg_skid_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    input  wire logic             flush_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    initial begin
        if (DEPTH != 2) begin
            $error("cfg_skid_buffer supports exactly two entries.");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];        // Storage entries.
    logic [WIDTH-1:0] next_mem [DEPTH];   // Next storage entries.
    logic             wr_ptr;             // Write slot.
    logic             rd_ptr;             // Read slot.
    logic [1:0]       count;              // Occupied entries.
    logic             next_wr_ptr;        // Next write slot.
    logic             next_rd_ptr;        // Next read slot.
    logic [1:0]       next_count;         // Next occupancy.
    logic             push;               // A byte enters.
    logic             pop;                // A byte leaves.

    // Handshakes are honest: full refuses, empty offers nothing.
    assign in_ready_o  = (count != 2'd2);
    assign out_valid_o = (count != 2'd0);
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Next pointer, occupancy and storage values.
    always_comb begin
        next_mem    = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (flush_i) begin
            // A flush empties the buffer.
            next_wr_ptr = 1'b0;
            next_rd_ptr = 1'b0;
            next_count  = 2'd0;
        end else begin
            if (push) begin
                next_mem[wr_ptr] = in_data_i;
                next_wr_ptr      = ~wr_ptr;
            end
            if (pop) begin
                next_rd_ptr = ~rd_ptr;
            end
            next_count = count + {1'b0, push} - {1'b0, pop};
        end
    end

    // Register the buffer state.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'd0;
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
            mem    <= next_mem;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/cfg_load_chk.sv
// Concurrent checks on the ports of the configuration loader.
`timescale 1ns/1ps
`default_nettype none
module cfg_load_chk
    import cfg_load_pkg::*;
#(
    parameter int INIT_LEN = 2  // Initialization cycles that precede user mode.
) (
    input wire logic                            CLK_I,
    input wire logic                            RESET_N_I,
    input wire logic                            CONFIG_RESTART_N_I,
    input wire logic                            SUPPLY_OK_I,
    input wire logic [cfg_load_pkg::ADDR_W-1:0] MEM_ADDR_O,
    input wire logic                            MEM_READ_O,
    input wire logic                            MEM_VALID_I,
    input wire logic                            ARRAY_VALID_O,
    input wire logic                            ARRAY_READY_I,
    input wire logic [cfg_load_pkg::DATA_W-1:0] ARRAY_DATA_O,
    input wire logic                            STATUS_ERROR_N_OE_O,
    input wire logic                            CRC_ERROR_O,
    input wire logic                            BROWNOUT_ERROR_O,
    input wire logic                            CONFIGURING_O,
    input wire logic                            USER_MODE_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RESET_N_I);
    int unsigned init_cnt;  // Consecutive cycles spent configuring without reading.
    // Counts the quiet cycles that must come before user mode.
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            init_cnt <= 0;
        end else if (CONFIGURING_O && !MEM_READ_O) begin
            init_cnt <= init_cnt + 1;
        end else begin
            init_cnt <= 0;
        end
    end
    start_addr_a: assert property (
        $rose(CONFIGURING_O) |-> MEM_READ_O && !CRC_ERROR_O && !BROWNOUT_ERROR_O
        && (MEM_ADDR_O == ADDR_LOW || MEM_ADDR_O == ADDR_HIGH)) else $error("bad load start");
    addr_step_a: assert property (
        $changed(MEM_ADDR_O) && $past(MEM_READ_O) |-> $past(MEM_VALID_I)
        && (MEM_ADDR_O == $past(MEM_ADDR_O) + 18'h00001
        || MEM_ADDR_O == $past(MEM_ADDR_O) - 18'h00001)) else $error("address step wrong");
    user_init_a: assert property (
        $rose(USER_MODE_O) |-> init_cnt >= INIT_LEN) else $error("user mode too early");
    user_clean_a: assert property (
        USER_MODE_O |-> !CONFIGURING_O && !MEM_READ_O && !STATUS_ERROR_N_OE_O)
        else $error("user mode while loading");
    crc_halt_a: assert property (
        CRC_ERROR_O |-> !MEM_READ_O && !USER_MODE_O && STATUS_ERROR_N_OE_O)
        else $error("load not halted on check error");
    brown_stop_a: assert property (
        !SUPPLY_OK_I && (CONFIGURING_O || USER_MODE_O) |=> BROWNOUT_ERROR_O
        && STATUS_ERROR_N_OE_O && !USER_MODE_O) else $error("supply loss not flagged");
    brown_wait_a: assert property (
        BROWNOUT_ERROR_O && !SUPPLY_OK_I |=> !USER_MODE_O && !CONFIGURING_O)
        else $error("resumed during supply loss");
    auto_reload_a: assert property (
        BROWNOUT_ERROR_O && SUPPLY_OK_I && CONFIG_RESTART_N_I |=> MEM_READ_O
        && !BROWNOUT_ERROR_O) else $error("no reload after supply return");
    error_hold_a: assert property (
        $fell(STATUS_ERROR_N_OE_O) |-> $rose(CONFIGURING_O)) else $error("error released early");
    pin_drive_a: assert property (
        STATUS_ERROR_N_OE_O == (CRC_ERROR_O || BROWNOUT_ERROR_O)) else $error("pin drive wrong");
    array_hold_a: assert property (
        ARRAY_VALID_O && !ARRAY_READY_I |=> ARRAY_VALID_O && $stable(ARRAY_DATA_O))
        else $error("stalled byte dropped");
endmodule
bind config_load_crc_recovery cfg_load_chk #(.INIT_LEN(INIT_LEN)) u_chk (
    .CLK_I, .RESET_N_I, .CONFIG_RESTART_N_I, .SUPPLY_OK_I, .MEM_ADDR_O, .MEM_READ_O,
    .MEM_VALID_I, .ARRAY_VALID_O, .ARRAY_READY_I, .ARRAY_DATA_O, .STATUS_ERROR_N_OE_O,
    .CRC_ERROR_O, .BROWNOUT_ERROR_O, .CONFIGURING_O, .USER_MODE_O
);
`default_nettype wire

// ===== testbench/cfg_mem_model.sv
// Behavioural configuration memory that answers the loader's reads.
`timescale 1ns/1ps
`default_nettype none
module cfg_mem_model
    import cfg_load_pkg::*;
#(
    parameter int FRAME_LEN = 2  // Payload bytes per frame.
) (
    input  wire logic                            clk_i,
    input  wire logic                            reset_n_i,
    input  wire logic                            desc_i,
    input  wire logic                            slow_i,
    input  wire logic                            bad_crc_i,
    input  wire logic [cfg_load_pkg::ADDR_W-1:0] addr_i,
    input  wire logic                            read_i,
    output logic                                 valid_o,
    output logic      [cfg_load_pkg::DATA_W-1:0] data_o
);
    logic [ADDR_W-1:0] seen;  // Address presented in the previous cycle.
    logic [DATA_W-1:0] word;  // Byte stored at the current address.
    logic [15:0]       crc;   // Check value of the frame being read.
    int                idx;   // Position in the stream.
    int                pos;   // Position inside the frame.
    // Check value over one frame's payload, each byte fed low bit first.
    function automatic logic [15:0] frame_crc(input int base);
        logic [15:0] c;
        logic [7:0]  b;
        c = CRC_INIT;
        for (int k = 0; k < FRAME_LEN; k++) begin
            b = 8'(base + k) ^ 8'ha5;
            for (int i = 0; i < 8; i++) begin
                c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? CRC_POLY : 16'h0000);
            end
        end
        return c;
    endfunction
    // The stream starts at the base address itself; no offset is added here.
    always_comb begin
        idx = desc_i ? int'(ADDR_HIGH - addr_i) : int'(addr_i);
        pos = idx % (FRAME_LEN + 2);
        crc = frame_crc(idx - pos);
        if (pos < FRAME_LEN) begin
            word = 8'(idx) ^ 8'ha5;
        end else if (pos == FRAME_LEN) begin
            word = crc[7:0];
        end else begin
            word = crc[15:8] ^ {7'h00, bad_crc_i};
        end
    end
    // A slow memory needs one cycle on a new address; the byte then stays until it moves.
    assign valid_o = read_i && (!slow_i || addr_i == seen);
    // Outside a valid byte the lines show garbage rather than the last value.
    assign data_o = valid_o ? word : ~word;
    // Remembers the address to spot a fresh request.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            seen <= '0;
        end else begin
            seen <= addr_i;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/config_load_crc_recovery_tb.sv
// Self-checking bench for the configuration loader.
`timescale 1ns/1ps
`default_nettype none
module config_load_crc_recovery_tb;
    import cfg_load_pkg::*;
    localparam int FL = 2;  // Payload bytes per frame.
    localparam int FR = 2;  // Frames per load.
    localparam int IL = 2;  // Initialization cycles.
    logic        clk, reset_n, restart_n, asc, desc, supply_ok, ready, slow, bad_crc;
    logic        mem_read, mem_valid, arr_valid, err_n, err_oe, crc_err, brown_err;
    logic        configuring, user_mode, pin_n;
    logic [17:0] mem_addr;
    logic [7:0]  mem_data, arr_data;
    int          n_mismatch, checks, rx, cyc;
    // The released status pin is pulled up.
    assign pin_n = err_oe ? err_n : 1'b1;
    config_load_crc_recovery #(.FRAME_LEN(FL), .FRAMES(FR), .INIT_LEN(IL)) u_dut (
        .CLK_I(clk), .RESET_N_I(reset_n), .CONFIG_RESTART_N_I(restart_n),
        .ASCENDING_PARALLEL_SCHEME_I(asc), .DESCENDING_PARALLEL_SCHEME_I(desc),
        .SUPPLY_OK_I(supply_ok), .MEM_ADDR_O(mem_addr), .MEM_READ_O(mem_read),
        .MEM_VALID_I(mem_valid), .MEM_DATA_I(mem_data), .ARRAY_VALID_O(arr_valid),
        .ARRAY_READY_I(ready), .ARRAY_DATA_O(arr_data), .STATUS_ERROR_N_I(pin_n),
        .STATUS_ERROR_N_O(err_n), .STATUS_ERROR_N_OE_O(err_oe), .CRC_ERROR_O(crc_err),
        .BROWNOUT_ERROR_O(brown_err), .CONFIGURING_O(configuring), .USER_MODE_O(user_mode));
    cfg_mem_model #(.FRAME_LEN(FL)) u_mem (
        .clk_i(clk), .reset_n_i(reset_n), .desc_i(desc && !asc), .slow_i(slow),
        .bad_crc_i(bad_crc), .addr_i(mem_addr), .read_i(mem_read), .valid_o(mem_valid),
        .data_o(mem_data));
    // Compares one value and counts the outcome.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Prints the verdict and ends the run.
    task stop_test();
        if (n_mismatch == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Each accepted array byte must be the next payload byte of the stream.
    always @(posedge clk) begin
        if (reset_n && arr_valid && ready) begin
            chk(arr_data, 8'((rx / FL) * (FL + 2) + rx % FL) ^ 8'ha5);
            rx++;
        end
    end
    // Host pulses the restart pin and checks where the load begins.
    task restart_load(input logic a, input logic d);
        @(posedge clk) restart_n <= 1'b0;
        asc <= a;
        desc <= d;
        @(posedge clk) restart_n <= 1'b1;
        rx = 0;
        @(posedge clk) #1 chk(mem_addr, (a || !d) ? ADDR_LOW : ADDR_HIGH);
        chk({mem_read, pin_n}, 2'h3);
    endtask
    // Waits for user mode under a bound.
    task wait_user();
        int n;
        n = 0;
        while (user_mode !== 1'b1 && n < 200) begin
            @(posedge clk) #1 n++;
        end
        chk(user_mode, 1'b1);
    endtask
    // Power-on load starts by itself at the ascending base address.
    task t_power_on();
        @(posedge clk) #1 chk({mem_read, mem_addr}, {1'b1, ADDR_LOW});
        wait_user();
        chk(rx, FR * FL);
    endtask
    // Every combination of the two scheme pins loads to user mode.
    task t_schemes();
        for (int m = 0; m < 4; m++) begin
            restart_load(m[0], m[1]);
            wait_user();
        end
    endtask
    // Slow memory and a stalled array: nothing may be lost.
    task t_stall();
        @(posedge clk) slow <= 1'b1;
        ready <= 1'b0;
        restart_load(1'b0, 1'b1);
        repeat (16) @(posedge clk);
        #1 chk({arr_valid, mem_read, mem_addr}, {2'h3, 18'h3fffb});
        @(posedge clk) ready <= 1'b1;
        wait_user();
        chk(rx, FR * FL);
        @(posedge clk) slow <= 1'b0;
    endtask
    // A corrupt check value halts the load and holds the pin low.
    task t_crc();
        int n;
        n = 0;
        @(posedge clk) bad_crc <= 1'b1;
        restart_load(1'b1, 1'b0);
        while (crc_err !== 1'b1 && n < 50) begin
            @(posedge clk) #1 n++;
        end
        chk({crc_err, pin_n, mem_read}, 3'h4);
        repeat (5) @(posedge clk);
        #1 chk({pin_n, user_mode, rx[3:0]}, {2'h0, 4'(FL)});
        @(posedge clk) bad_crc <= 1'b0;
        restart_load(1'b1, 1'b0);
        wait_user();
    endtask
    // Supply loss in user mode, then reload by tied restart or by the host.
    task t_brownout(input logic tied);
        @(posedge clk) supply_ok <= 1'b0;
        @(posedge clk) #1 chk({brown_err, pin_n, user_mode}, 3'h4);
        @(posedge clk) restart_n <= tied;
        repeat (4) @(posedge clk);
        #1 chk({user_mode, configuring}, 2'h0);
        @(posedge clk) supply_ok <= 1'b1;
        rx = 0;
        if (!tied) begin
            repeat (6) @(posedge clk);
            #1 chk({configuring, user_mode, brown_err}, 3'h1);
            @(posedge clk) restart_n <= 1'b1;
        end
        wait_user();
        chk({brown_err, rx[3:0]}, {1'b0, 4'(FR * FL)});
    endtask
    // Free-running clock at 20 MHz.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Bounds the run in case the loader hangs.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            stop_test();
        end
    end
    // Main sequence.
    initial begin
        {n_mismatch, checks, rx, cyc} = '0;
        {reset_n, asc, desc, slow, bad_crc} = '0;
        {restart_n, supply_ok, ready} = 3'h7;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        t_power_on();
        t_schemes();
        t_stall();
        t_crc();
        t_brownout(1'b1);
        t_brownout(1'b0);
        stop_test();
    end
endmodule
`default_nettype wire
